// [common/ucmc_pkg.sv]
// Constants shared by the USB charge mode controller
package ucmc_pkg;

  // ****************************************
  // APB register map
  // ****************************************
  localparam logic [11:0] CTRL_OFF   = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam int          CTRL_FORCE_DIS_BIT = 0;
  localparam logic        CTRL_RESET         = 1'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ         = 50_000_000;
  localparam int PULSE_TIME_MS  = 350;
  localparam int DEGLITCH_MS    = 9;
  localparam int FALLBACK_S     = 10;
  localparam int OT_RELEASE_MS  = 1;
  localparam int PULSE_CYC      = PULSE_TIME_MS * (CLK_HZ / 1000);
  localparam int DEGLITCH_CYC   = DEGLITCH_MS * (CLK_HZ / 1000);
  localparam int FALLBACK_CYC   = FALLBACK_S * CLK_HZ;
  localparam int OT_RELEASE_CYC = OT_RELEASE_MS * (CLK_HZ / 1000);

  // ****************************************
  // Mode-select codes and decoded modes
  // ****************************************
  localparam logic [2:0] CODE_OFF    = 3'h0;
  localparam logic [2:0] CODE_DCPA   = 3'h1;
  localparam logic [2:0] CODE_SDPRW  = 3'h2;
  localparam logic [2:0] CODE_CDPRW  = 3'h3;
  localparam logic [2:0] CODE_BC12   = 3'h4;
  localparam logic [2:0] CODE_DIV    = 3'h5;
  localparam logic [2:0] CODE_SDP    = 3'h6;
  localparam logic [2:0] CODE_CDP    = 3'h7;

  typedef enum logic [2:0] {
    UCMC_OFF    = 3'b000,
    UCMC_DCPA   = 3'b001,
    UCMC_SDPRW  = 3'b010,
    UCMC_CDPRW  = 3'b011,
    UCMC_BC12   = 3'b100,
    UCMC_DIV    = 3'b101,
    UCMC_SDP    = 3'b110,
    UCMC_CDP    = 3'b111
  } ucmc_mode_t;

endpackage

// [core/ucmc_ctrl.sv]
// USB charge mode controller: mode decode, discharge pulse, alert output
// ****************************************
// Notes on behaviour
// ****************************************
// Notes on behaviour
// - Code 000: power, data switch, emulation off; discharge on.
// - Code 110 gives standard port; code 111 charging port with detect.
// - Code 010 gives standard port with remote wakeup for all devices.
// - Code 011: charging port with wakeup for low speed, else DCP auto.
// - Code 001 gives DCP auto-detect with detection, no wakeup.
// - Code 101 forced divider, code 100 forced BC1.2 shorted mode.
// - Auto mode starts as divider; negotiation gives pulse then BC1.2.
// - Detach in auto BC1.2 returns to divider after about 10 s.
// - Wakeup transitions keep data switch on and skip the pulse.
// - Staying at 011, fast device or detach moves to DCP auto itself.
// - Other mode changes apply a discharge pulse of 350 ms.
// - Discharge held on while enable low or code 000.
// - Open-drain low alert on overcurrent or overtemperature; overcurrent alert drops as soon as it clears.
// - Overcurrent alert only after 9 ms of persistence.
// - Overtemperature alert at once; released after delay on cooling.
// - Switch off above 150 C, back on after cooling by 20 C.
// - Undervoltage lockout: all off, discharge on, alert released.
// - Enable low: all off, discharge on, alert released.
`timescale 1ns/100ps

module ucmc_ctrl #(
  parameter int PULSE_CYC      = ucmc_pkg::PULSE_CYC,
  parameter int DEGLITCH_CYC   = ucmc_pkg::DEGLITCH_CYC,
  parameter int FALLBACK_CYC   = ucmc_pkg::FALLBACK_CYC,
  parameter int OT_RELEASE_CYC = ucmc_pkg::OT_RELEASE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mode_select_bit1,
  input  wire logic        mode_select_bit2,
  input  wire logic        mode_select_bit3,
  input  wire logic        enable,
  input  wire logic        supply_ok,
  input  wire logic        overcurrent,
  input  wire logic        die_hot,
  input  wire logic        die_cooled,
  input  wire logic        negotiation_seen,
  input  wire logic        device_present,
  input  wire logic        fast_device,
  output logic             power_switch_on,
  output logic             data_switch_on,
  output logic             discharge_on,
  output logic             remote_wakeup_on,
  output logic             cdp_profile_on,
  output logic             divider_profile_on,
  output logic             short_profile_on,
  output logic             alert_o,
  output logic             alert_oe_n
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic        prev_present;
    logic [2:0]  code;
    logic [2:0]  mode;
    logic        rw_auto;
    logic        auto_bc12;
    logic        pend_bc12;
    logic        pulse_on;
    logic [31:0] pulse_cnt;
    logic        fb_on;
    logic [31:0] fb_cnt;
    logic [31:0] oc_cnt;
    logic        oc_alert;
    logic        ot_latch;
    logic        ot_alert;
    logic [31:0] ot_cnt;
    logic        force_dis;
    logic [31:0] prdata;
  } ucmc_state_t;

  ucmc_state_t st;
  ucmc_state_t next_st;

  logic [2:0] code_in;
  logic       en_s;
  logic       ok_s;
  logic       oc_s;
  logic       hot_s;
  logic       cool_s;
  logic       neg_s;
  logic       pres_s;
  logic       fast_s;
  logic       active;
  logic       run;
  logic       detach;
  logic       auto_eff;
  logic       wake_pair;
  logic       rd_map;
  logic [31:0] status_word;

  // Second sync stage only feeds logic
  assign code_in = st.sync2[2:0];
  assign en_s    = st.sync2[3];
  assign ok_s    = st.sync2[4];
  assign oc_s    = st.sync2[5];
  assign hot_s   = st.sync2[6];
  assign cool_s  = st.sync2[7];
  assign neg_s   = st.sync2[8];
  assign pres_s  = st.sync2[9];
  assign fast_s  = st.sync2[10];

  assign active   = en_s && ok_s && (code_in != ucmc_pkg::CODE_OFF);
  // Nothing switches on before the new code is decoded
  assign run      = active && (st.code != ucmc_pkg::CODE_OFF) &&
                    !st.pulse_on && !st.force_dis;
  assign detach   = st.prev_present && !pres_s;
  assign auto_eff = (st.mode == ucmc_pkg::UCMC_DCPA) || st.rw_auto;

  // Wakeup-preserving code pairs
  always_comb begin
    wake_pair = 1'b0;
    if ((st.code == ucmc_pkg::CODE_SDP && code_in == ucmc_pkg::CODE_SDPRW) ||
        (st.code == ucmc_pkg::CODE_SDPRW && code_in == ucmc_pkg::CODE_SDP)) begin
      wake_pair = 1'b1;
    end
    if (((st.code[1:0] == 2'h2 || st.code == ucmc_pkg::CODE_CDP) &&
         code_in == ucmc_pkg::CODE_CDPRW) ||
        (st.code == ucmc_pkg::CODE_CDPRW &&
         (code_in[1:0] == 2'h2 || code_in == ucmc_pkg::CODE_CDP))) begin
      wake_pair = !st.rw_auto && !fast_s;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    // First pin is the top bit of the mode code
    next_st.sync1 = {fast_device, device_present, negotiation_seen,
                     die_cooled, die_hot, overcurrent, supply_ok, enable,
                     mode_select_bit1, mode_select_bit2, mode_select_bit3};
    next_st.sync2 = st.sync1;
    next_st.prev_present = pres_s;

    // Mode tracking
    if (!active) begin
      next_st.code      = ucmc_pkg::CODE_OFF;
      next_st.mode      = ucmc_pkg::UCMC_OFF;
      next_st.rw_auto   = 1'b0;
      next_st.auto_bc12 = 1'b0;
      next_st.pend_bc12 = 1'b0;
      next_st.pulse_on  = 1'b0;
      next_st.pulse_cnt = 32'h0;
      next_st.fb_on     = 1'b0;
      next_st.fb_cnt    = 32'h0;
    end else if (code_in != st.code) begin
      next_st.code      = code_in;
      next_st.mode      = code_in;
      next_st.auto_bc12 = 1'b0;
      next_st.pend_bc12 = 1'b0;
      next_st.fb_on     = 1'b0;
      next_st.fb_cnt    = 32'h0;
      next_st.rw_auto   = (code_in == ucmc_pkg::CODE_CDPRW) && fast_s;
      next_st.pulse_on  = !wake_pair;
      next_st.pulse_cnt = 32'h0;
    end else begin
      if (st.mode == ucmc_pkg::UCMC_CDPRW && !st.rw_auto &&
          (fast_s || detach)) begin
        next_st.rw_auto   = 1'b1;
        next_st.pulse_on  = 1'b1;
        next_st.pulse_cnt = 32'h0;
      end
      if (auto_eff && !st.auto_bc12 && !st.pend_bc12 && neg_s) begin
        next_st.pend_bc12 = 1'b1;
        next_st.pulse_on  = 1'b1;
        next_st.pulse_cnt = 32'h0;
      end
      if (st.pulse_on) begin
        if (st.pulse_cnt == 32'(PULSE_CYC - 1)) begin
          next_st.pulse_on  = 1'b0;
          next_st.pulse_cnt = 32'h0;
          if (st.pend_bc12) begin
            next_st.auto_bc12 = 1'b1;
            next_st.pend_bc12 = 1'b0;
          end
        end else begin
          next_st.pulse_cnt = st.pulse_cnt + 32'h1;
        end
      end
      // Fallback to divider after a detach
      if (auto_eff && st.auto_bc12) begin
        if (pres_s && !st.prev_present) begin
          next_st.fb_on  = 1'b0;
          next_st.fb_cnt = 32'h0;
        end else if (detach) begin
          next_st.fb_on  = 1'b1;
          next_st.fb_cnt = 32'h0;
        end else if (st.fb_on) begin
          if (st.fb_cnt == 32'(FALLBACK_CYC - 1)) begin
            next_st.fb_on     = 1'b0;
            next_st.fb_cnt    = 32'h0;
            next_st.auto_bc12 = 1'b0;
          end else begin
            next_st.fb_cnt = st.fb_cnt + 32'h1;
          end
        end
      end
    end

    // Thermal latch
    if (hot_s) begin
      next_st.ot_latch = 1'b1;
    end else if (cool_s) begin
      next_st.ot_latch = 1'b0;
    end

    // Alert sources
    if (!en_s || !ok_s) begin
      next_st.oc_cnt   = 32'h0;
      next_st.oc_alert = 1'b0;
      next_st.ot_alert = 1'b0;
      next_st.ot_cnt   = 32'h0;
    end else begin
      if (!oc_s) begin
        next_st.oc_cnt   = 32'h0;
        next_st.oc_alert = 1'b0;
      end else if (st.oc_cnt == 32'(DEGLITCH_CYC - 1)) begin
        next_st.oc_alert = 1'b1;
      end else begin
        next_st.oc_cnt = st.oc_cnt + 32'h1;
      end
      if (hot_s) begin
        next_st.ot_alert = 1'b1;
        next_st.ot_cnt   = 32'h0;
      end else if (st.ot_alert && !st.ot_latch) begin
        if (st.ot_cnt == 32'(OT_RELEASE_CYC - 1)) begin
          next_st.ot_alert = 1'b0;
          next_st.ot_cnt   = 32'h0;
        end else begin
          next_st.ot_cnt = st.ot_cnt + 32'h1;
        end
      end
    end

    // APB access
    if (psel && !penable) begin
      next_st.prdata = rd_map ? status_word : 32'h0;
      if (paddr == ucmc_pkg::CTRL_OFF) begin
        next_st.prdata = {31'h0, st.force_dis};
      end
    end
    if (psel && penable && pwrite && paddr == ucmc_pkg::CTRL_OFF) begin
      next_st.force_dis = pwdata[ucmc_pkg::CTRL_FORCE_DIS_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st           <= '0;
      st.force_dis <= ucmc_pkg::CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  assign rd_map = (paddr == ucmc_pkg::CTRL_OFF) ||
                  (paddr == ucmc_pkg::STATUS_OFF);
  assign status_word = {18'h0, st.ot_latch, st.ot_alert, st.oc_alert,
                        st.fb_on, st.auto_bc12, st.rw_auto, st.pulse_on,
                        active, st.code, st.mode};
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_map;
  assign prdata  = st.prdata;

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    power_switch_on    = run && !st.ot_latch;
    discharge_on       = !active || st.pulse_on || st.force_dis;
    data_switch_on     = run && !st.rw_auto &&
                         (st.mode == ucmc_pkg::UCMC_SDP ||
                          st.mode == ucmc_pkg::UCMC_CDP ||
                          st.mode == ucmc_pkg::UCMC_SDPRW ||
                          st.mode == ucmc_pkg::UCMC_CDPRW);
    remote_wakeup_on   = run && (st.mode == ucmc_pkg::UCMC_SDPRW ||
                         (st.mode == ucmc_pkg::UCMC_CDPRW &&
                          !st.rw_auto));
    cdp_profile_on     = run && (st.mode == ucmc_pkg::UCMC_CDP ||
                         (st.mode == ucmc_pkg::UCMC_CDPRW &&
                          !st.rw_auto));
    divider_profile_on = run && ((auto_eff && !st.auto_bc12) ||
                         st.mode == ucmc_pkg::UCMC_DIV);
    short_profile_on   = run && ((auto_eff && st.auto_bc12) ||
                         st.mode == ucmc_pkg::UCMC_BC12);
    alert_o            = 1'b0;
    alert_oe_n         = !(en_s && (st.oc_alert || st.ot_alert));
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  off_outputs_a: assert property (!active |->
    !power_switch_on && !data_switch_on && discharge_on && !cdp_profile_on)
    else $error("Outputs not off while inactive");
  off_code_a: assert property (st.code == ucmc_pkg::CODE_OFF |->
    !power_switch_on && !data_switch_on)
    else $error("Switch on before mode decoded");
  disabled_alert_a: assert property (!en_s |-> alert_oe_n)
    else $error("Alert driven while disabled");
  disch_hold_a: assert property (!en_s |-> discharge_on)
    else $error("Discharge off while disabled");
  decode_a: assert property (active && code_in != st.code |=>
    st.mode == $past(code_in))
    else $error("Mode not taken from code");
  auto_start_a: assert property (active && code_in != st.code &&
    code_in == ucmc_pkg::CODE_DCPA |=> st.pulse_on && !st.auto_bc12)
    else $error("Auto mode not started as divider");
  cdp_prof_a: assert property (run &&
    st.mode == ucmc_pkg::UCMC_CDP |-> cdp_profile_on && data_switch_on &&
    !remote_wakeup_on)
    else $error("Charging port profile wrong");
  sdp_wake_a: assert property (run &&
    st.mode == ucmc_pkg::UCMC_SDPRW |-> remote_wakeup_on && data_switch_on)
    else $error("Wakeup standard port profile wrong");
  rw_auto_prof_a: assert property (run && st.rw_auto |->
    !data_switch_on && (divider_profile_on || short_profile_on))
    else $error("Automatic DCP profile wrong");
  pulse_len_a: assert property ($fell(st.pulse_on) && active &&
    $past(active) |-> $past(st.pulse_cnt) == 32'(PULSE_CYC - 1))
    else $error("Discharge pulse wrong length");
  oc_deglitch_a: assert property ($rose(st.oc_alert) |->
    $past(st.oc_cnt) == 32'(DEGLITCH_CYC - 1) && $past(oc_s))
    else $error("Overcurrent alert before deglitch");
  oc_hold_a: assert property (st.oc_alert && oc_s &&
    en_s && ok_s |=> st.oc_alert)
    else $error("Overcurrent alert dropped early");
  ot_fast_a: assert property (hot_s && en_s && ok_s |=> st.ot_alert)
    else $error("Overtemperature alert late");
  thermal_off_a: assert property (hot_s |=> !power_switch_on)
    else $error("Switch on while hot");
  wake_keep_a: assert property (active && $past(active) &&
    data_switch_on && wake_pair && code_in != st.code |=> data_switch_on)
    else $error("Wakeup transition dropped data switch");
  rw_switch_a: assert property (active && code_in == st.code &&
    st.mode == ucmc_pkg::UCMC_CDPRW && !st.rw_auto && (fast_s || detach)
    |=> st.rw_auto)
    else $error("No automatic move to DCP auto");
  bc12_after_a: assert property ($rose(st.auto_bc12) |->
    $past(st.pulse_on) && $past(st.pend_bc12))
    else $error("BC1.2 entered without pulse");
  bc12_prof_a: assert property (run &&
    st.mode == ucmc_pkg::UCMC_BC12 |-> short_profile_on &&
    !divider_profile_on)
    else $error("Forced BC1.2 profile wrong");
  fallback_a: assert property ($fell(st.auto_bc12) && active &&
    st.code == $past(st.code) |-> $past(st.fb_cnt) == 32'(FALLBACK_CYC - 1))
    else $error("Fallback timer wrong");
  uvlo_off_a: assert property (!ok_s |=>
    !power_switch_on && !data_switch_on)
    else $error("Active under lockout");

  pulse_c: cover property ($fell(st.pulse_on));
  bc12_c: cover property ($rose(st.auto_bc12));
  rwauto_c: cover property ($rose(st.rw_auto));
  oc_alert_c: cover property ($rose(st.oc_alert));
  wake_c: cover property (active && wake_pair && code_in != st.code);

endmodule

// [tb/ucmc_host.sv]
// Host controller model driving the mode-select pins and enable
`timescale 1ns/100ps
module ucmc_host (
  input  wire logic pclk,
  input  wire logic alert_pin_n,
  output logic      mode_select_bit1,
  output logic      mode_select_bit2,
  output logic      mode_select_bit3,
  output logic      enable
);
  logic       react;
  logic       en_q;
  logic [2:0] code_q;

  initial begin
    {react, code_q} = 4'h0;
    en_q = 1'b1;
    {mode_select_bit3, mode_select_bit2, mode_select_bit1, enable} = 4'h1;
  end

  task automatic set_code(input logic [2:0] c);
    code_q <= c;
  endtask

  // All pins move on one edge, so no in-between code shows
  always @(posedge pclk) begin
    {mode_select_bit1, mode_select_bit2, mode_select_bit3} <= code_q;
    enable <= en_q;
    if (react && !alert_pin_n) begin
      en_q <= 1'b0;
    end else if (!react) begin
      en_q <= 1'b1;
    end
  end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the charge mode controller
`timescale 1ns/100ps
module tb_top;
  localparam int PC = 20;
  localparam int DC = 10;
  localparam int FC = 40;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        mode_select_bit1, mode_select_bit2, mode_select_bit3, enable;
  logic        supply_ok, overcurrent, die_hot, die_cooled;
  logic        negotiation_seen, device_present, fast_device;
  logic        power_switch_on, data_switch_on, discharge_on;
  logic        remote_wakeup_on, cdp_profile_on, divider_profile_on;
  logic        short_profile_on, alert_o, alert_oe_n, alert_pin_n;
  logic [6:0]  outs;
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc = 0;

  assign outs = {power_switch_on, data_switch_on, discharge_on,
    remote_wakeup_on, cdp_profile_on, divider_profile_on, short_profile_on};
  // Open-drain pin with pull-up
  assign alert_pin_n = alert_oe_n ? 1'b1 : alert_o;

  ucmc_ctrl #(.PULSE_CYC(PC), .DEGLITCH_CYC(DC), .FALLBACK_CYC(FC),
    .OT_RELEASE_CYC(5)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .mode_select_bit1,
    .mode_select_bit2, .mode_select_bit3, .enable, .supply_ok, .overcurrent,
    .die_hot, .die_cooled, .negotiation_seen, .device_present, .fast_device,
    .power_switch_on, .data_switch_on, .discharge_on, .remote_wakeup_on,
    .cdp_profile_on, .divider_profile_on, .short_profile_on, .alert_o,
    .alert_oe_n);

  ucmc_host u_host (.pclk, .alert_pin_n, .mode_select_bit1,
    .mode_select_bit2, .mode_select_bit3, .enable);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      end_sim();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [39:0] res);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    res = {7'h0, pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Pulse seen mid-change, then the settled output set
  task automatic step(input logic [2:0] c, input logic pul,
                      input logic [6:0] exp);
    u_host.set_code(c);
    wt(6);
    chk({discharge_on, power_switch_on}, {pul | (c == 3'h0),
      !pul && (c != 3'h0)});
    wt(PC + 6);
    chk(outs, exp);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_modes();
    step(3'h6, 1'b1, 7'h60);
    step(3'h2, 1'b0, 7'h68);
    step(3'h3, 1'b0, 7'h6C);
    step(3'h7, 1'b0, 7'h64);
    step(3'h1, 1'b1, 7'h42);
    step(3'h5, 1'b1, 7'h42);
    step(3'h4, 1'b1, 7'h41);
    step(3'h0, 1'b1, 7'h10);
  endtask

  task automatic t_auto();
    step(3'h1, 1'b1, 7'h42);
    negotiation_seen <= 1'b1;
    wt(6);
    chk(discharge_on, 1'b1);
    negotiation_seen <= 1'b0;
    wt(PC + 6);
    chk(outs, 7'h41);
    device_present <= 1'b0;
    wt(FC / 2);
    chk(short_profile_on, 1'b1);
    wt(FC + PC + 10);
    chk(outs, 7'h42);
    device_present <= 1'b1;
    step(3'h3, 1'b1, 7'h6C);
    fast_device <= 1'b1;
    wt(6);
    chk(discharge_on, 1'b1);
    wt(PC + 6);
    chk(outs, 7'h42);
    fast_device <= 1'b0;
  endtask

  task automatic t_alert();
    step(3'h6, 1'b1, 7'h60);
    overcurrent <= 1'b1;
    wt(DC - 3);
    overcurrent <= 1'b0;
    wt(6);
    chk(alert_oe_n, 1'b1);
    overcurrent <= 1'b1;
    wt(DC - 3);
    chk(alert_oe_n, 1'b1);
    wt(10);
    chk({alert_oe_n, alert_pin_n}, 2'b00);
    overcurrent <= 1'b0;
    wt(6);
    chk(alert_oe_n, 1'b1);
    die_hot <= 1'b1;
    wt(4);
    chk({alert_oe_n, power_switch_on}, 2'b00);
    die_hot <= 1'b0;
    die_cooled <= 1'b1;
    wt(3);
    chk(alert_oe_n, 1'b0);
    wt(10);
    chk({alert_oe_n, power_switch_on}, 2'b11);
    die_cooled <= 1'b0;
    u_host.react <= 1'b1;
    overcurrent <= 1'b1;
    wt(DC + 14);
    chk({alert_oe_n, outs}, 8'h90);
    overcurrent <= 1'b0;
    u_host.react <= 1'b0;
    wt(PC + 10);
    supply_ok <= 1'b0;
    wt(6);
    chk(outs & 7'h6F, 7'h00);
    supply_ok <= 1'b1;
    wt(PC + 10);
  endtask

  task automatic t_apb();
    logic [39:0] r;
    apb(1'b0, ucmc_pkg::CTRL_OFF, 32'h0, r);
    chk(r, 40'h0);
    apb(1'b1, ucmc_pkg::CTRL_OFF, 32'h1, r);
    apb(1'b0, ucmc_pkg::CTRL_OFF, 32'h0, r);
    chk(r, 40'h1);
    wt(2);
    chk(discharge_on, 1'b1);
    apb(1'b1, ucmc_pkg::CTRL_OFF, 32'h0, r);
    apb(1'b0, 12'h008, 32'h0, r);
    chk(r, 40'h1_0000_0000);
    apb(1'b0, ucmc_pkg::STATUS_OFF, 32'h0, r);
    chk(r, 40'h40 | {ucmc_pkg::CODE_SDP, ucmc_pkg::CODE_SDP});
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {supply_ok, device_present} = 2'h3;
    {overcurrent, die_hot, die_cooled, negotiation_seen, fast_device} = '0;
    presetn = 1'b0;
    wt(4);
    chk({alert_oe_n, outs}, 8'h90);
    wt(4);
    presetn <= 1'b1;
    wt(1);
    t_modes();
    t_auto();
    t_alert();
    t_apb();
    end_sim();
  end
endmodule
